//--- hw/gpab_pkg.sv
// Package for the two-port GPIO block: register map, fields, reset values, carrier types
package gpab_pkg;

    // ------------------------------------------------------------
    // Register indices (printed offsets are not all multiples of 4)
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_A_DATA_IDX = 8'h00;  // port_a_data_latch
    localparam logic [7:0] PORT_B_DATA_IDX = 8'h01;  // port_b_data_latch
    localparam logic [7:0] PORT_A_DIR_IDX  = 8'h04;  // port_a_direction
    localparam logic [7:0] PORT_B_DIR_IDX  = 8'h05;  // port_b_direction
    localparam logic [7:0] PORT_A_LED_IDX  = 8'h08;  // port_a_led_drive
    localparam logic [7:0] OVR_CTRL_IDX    = 8'h0c;  // peripheral override enables
    localparam logic [7:0] ANA_SEL_IDX     = 8'h0d;  // analog channel select
    localparam logic [7:0] PIN_DRIVE_IDX   = 8'h10;  // read-only pin drive state

    // ------------------------------------------------------------
    // Field positions in the override control register
    // ------------------------------------------------------------
    localparam int OVR_IIC_BIT    = 0;   // iic_module_enable
    localparam int OVR_SCI_BIT    = 1;   // serial_module_enable
    localparam int OVR_T1C0_LSB   = 2;   // timer_one_channel_zero edge/level select
    localparam int OVR_T1C1_LSB   = 4;   // timer_one_channel_one
    localparam int OVR_T2C0_LSB   = 6;   // timer_two_channel_zero
    localparam int OVR_T2C1_LSB   = 8;   // timer_two_channel_one
    localparam int OVR_WIDTH      = 10;  // implemented control bits
    localparam int ANA_SEL_WIDTH  = 5;   // analog_channel_select field width

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  DIR_RESET     = 8'h00;  // all pins inputs
    localparam logic [7:0]  LED_RESET     = 8'h00;  // standard drive
    localparam logic [9:0]  OVR_RESET     = 10'h000; // no takeover
    localparam logic [4:0]  ANA_SEL_RESET = 5'h1f;  // no pin selected

    // ------------------------------------------------------------
    // AXI4-Lite response codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-pin pad drive carrier
    typedef struct packed {
        logic [7:0] dataOut;     // value driven when enabled
        logic [7:0] outEnable;   // high while the block drives the pin
    } gpab_pad_t;

    // Peripheral-side pin signals for port B
    typedef struct packed {
        logic [7:0] dataOut;     // peripheral output per pin
        logic [7:0] outEnable;   // peripheral wants to drive per pin
    } gpab_periph_t;

endpackage : gpab_pkg

//--- hw/gpab_port.sv
// One 8-bit port: latch, direction, pin drive and read-back mux
`timescale 1ns/1ps
module gpab_port
    import gpab_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Register writes
    input  wire logic             dataWe,
    input  wire logic             dirWe,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [WIDTH-1:0] wrMask,
    // Override from peripherals
    input  wire logic [WIDTH-1:0] takeover,
    input  wire logic [WIDTH-1:0] periphOut,
    input  wire logic [WIDTH-1:0] periphOe,
    input  wire logic [WIDTH-1:0] openDrain,
    // Pins
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOe,
    // Register views
    output logic      [WIDTH-1:0] dataRead,
    output logic      [WIDTH-1:0] latchValue,
    output logic      [WIDTH-1:0] dirValue
);

    logic [WIDTH-1:0] latch_reg;   // data latch, no reset
    logic [WIDTH-1:0] dir_reg;     // direction bits
    logic [WIDTH-1:0] rawOut;      // value before open-drain shaping
    logic [WIDTH-1:0] rawOe;       // enable before open-drain shaping

    // ------------------------------------------------------------
    // Data latch
    // ------------------------------------------------------------
    // Written whatever the direction; reset leaves it alone
    always_ff @(posedge clk) begin
        if (dataWe) begin
            latch_reg <= (latch_reg & ~wrMask) | (wrData & wrMask);
        end
    end

    // Direction bits, cleared by reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dir_reg <= DIR_RESET;
        end else if (dirWe) begin
            dir_reg <= (dir_reg & ~wrMask) | (wrData & wrMask);
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        // Override wins; stored registers untouched meanwhile
        rawOut = (takeover & periphOut) | (~takeover & latch_reg);
        rawOe  = (takeover & periphOe)  | (~takeover & dir_reg);
        // Open-drain pins only pull low: enable only when driving 0
        pinOe  = (openDrain & rawOe & ~rawOut) | (~openDrain & rawOe);
        pinOut = rawOut & ~openDrain;
    end

    // Outputs read latch, inputs read the pin
    assign dataRead   = (dir_reg & latch_reg) | (~dir_reg & pinIn);
    assign latchValue = latch_reg;
    assign dirValue   = dir_reg;

endmodule : gpab_port

//--- hw/gpab_top.sv
// Two GPIO ports with peripheral overrides behind an AXI4-Lite slave
//
// Notes on behaviour
// - direction 1 drives pin, 0 floats
// - reset clears all direction bits
// - reset leaves data latches untouched
// - output pins read back latch value
// - input pins read back pin level
// - latch writable in any direction
// - selected analog channel releases port A pin
// - LED bit gives strong sink on outputs
// - port B pins 0-3 open drain
// - IIC enable takes port B pins 0,1
// - serial enable takes port B pins 2,3
// - timer edge/level bits take pins 4-7
// - port B reads like port A
`timescale 1ns/1ps
module gpab_top
    import gpab_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Port A pins
    input  wire logic [7:0]  portAIn,
    output gpab_pad_t        portAPad,
    output logic      [7:0]  portALedSink,
    output logic      [7:0]  portAAnalogSel,
    // Port B pins
    input  wire logic [7:0]  portBIn,
    output gpab_pad_t        portBPad,
    // Port B peripheral side
    input  gpab_periph_t     portBPeriph,
    output logic      [7:0]  portBPeriphIn
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]               led_reg;      // port_a_led_drive
    logic [OVR_WIDTH-1:0]     ovr_reg;      // override enables
    logic [ANA_SEL_WIDTH-1:0] anaSel_reg;   // analog_channel_select

    // Write channel state
    logic [7:0]  awAddr_reg;   // captured write address
    logic        awHave_reg;   // address held
    logic [31:0] wData_reg;    // captured write data
    logic [3:0]  wStrb_reg;    // captured strobes
    logic        wHave_reg;    // data held
    logic        bValid_reg;   // response pending
    logic [1:0]  bResp_reg;    // response code
    // Read channel state
    logic        rValid_reg;   // read data pending
    logic [31:0] rData_reg;    // read data
    logic [1:0]  rResp_reg;    // read response

    // Port wiring
    logic        wrFire;       // write performed this cycle
    logic [7:0]  wrIdx;        // register index of write
    logic [7:0]  wrMask;       // byte lane 0 mask
    logic [7:0]  aTake;        // port A takeover
    logic [7:0]  bTake;        // port B takeover
    logic [7:0]  aRead;        // port A data view
    logic [7:0]  bRead;        // port B data view
    logic [7:0]  aLatch;       // port A latch
    logic [7:0]  bLatch;       // port B latch
    logic [7:0]  aDir;         // port A direction
    logic [7:0]  bDir;         // port B direction

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address to register index; low two bits ignored
    function automatic logic [7:0] addrToIdx(input logic [7:0] addr);
        addrToIdx = {2'h0, addr[7:2]};
    endfunction : addrToIdx

    // Timer pin is a channel pin when either select bit is set
    function automatic logic timerOwns(input logic [1:0] sel);
        timerOwns = |sel;
    endfunction : timerOwns

    // ------------------------------------------------------------
    // Pin takeover
    // ------------------------------------------------------------
    always_comb begin
        // Analog select picks one pin 0..7; higher codes pick none
        for (int i = 0; i < 8; i++) begin
            aTake[i] = (anaSel_reg == ANA_SEL_WIDTH'(i));
        end
        // IIC data and clock pins
        bTake[0] = ovr_reg[OVR_IIC_BIT];
        bTake[1] = ovr_reg[OVR_IIC_BIT];
        // Serial transmit and receive pins
        bTake[2] = ovr_reg[OVR_SCI_BIT];
        bTake[3] = ovr_reg[OVR_SCI_BIT];
        // Timer one owns pins 4,5; timer two owns 6,7
        bTake[4] = timerOwns(ovr_reg[OVR_T1C0_LSB +: 2]);
        bTake[5] = timerOwns(ovr_reg[OVR_T1C1_LSB +: 2]);
        bTake[6] = timerOwns(ovr_reg[OVR_T2C0_LSB +: 2]);
        bTake[7] = timerOwns(ovr_reg[OVR_T2C1_LSB +: 2]);
    end

    assign portAAnalogSel = aTake;
    // Peripherals always see the pin level
    assign portBPeriphIn  = portBIn;
    // Strong sink only on a port-controlled output pin
    assign portALedSink   = led_reg & aDir & ~aTake;

    // ------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------
    assign wrIdx  = addrToIdx(awAddr_reg);
    assign wrMask = {8{wStrb_reg[0]}};
    assign wrFire = awHave_reg && wHave_reg && !bValid_reg;
    // Port A has no digital takeover; analog select only releases it
    // Load latch before direction: the reverse order can glitch a pin

    gpab_port #(.WIDTH(8)) uPortA (
        .clk        (clk),
        .rstn       (rstn),
        .dataWe     (wrFire && wrIdx == PORT_A_DATA_IDX),
        .dirWe      (wrFire && wrIdx == PORT_A_DIR_IDX),
        .wrData     (wData_reg[7:0]),
        .wrMask     (wrMask),
        .takeover   (aTake),
        .periphOut  (8'h00),
        .periphOe   (8'h00),      // analog pin: buffer released
        .openDrain  (8'h00),
        .pinIn      (portAIn),
        .pinOut     (portAPad.dataOut),
        .pinOe      (portAPad.outEnable),
        .dataRead   (aRead),
        .latchValue (aLatch),
        .dirValue   (aDir)
    );

    gpab_port #(.WIDTH(8)) uPortB (
        .clk        (clk),
        .rstn       (rstn),
        .dataWe     (wrFire && wrIdx == PORT_B_DATA_IDX),
        .dirWe      (wrFire && wrIdx == PORT_B_DIR_IDX),
        .wrData     (wData_reg[7:0]),
        .wrMask     (wrMask),
        .takeover   (bTake),
        .periphOut  (portBPeriph.dataOut),
        .periphOe   (portBPeriph.outEnable),
        .openDrain  (8'h0f),
        .pinIn      (portBIn),
        .pinOut     (portBPad.dataOut),
        .pinOe      (portBPad.outEnable),
        .dataRead   (bRead),
        .latchValue (bLatch),
        .dirValue   (bDir)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Override and LED registers; override does not alter them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            led_reg    <= LED_RESET;
            ovr_reg    <= OVR_RESET;
            anaSel_reg <= ANA_SEL_RESET;
        end else if (wrFire) begin
            // Pin-drive view is read only: writes are dropped
            // LED drive enables, lane 0
            if (wrIdx == PORT_A_LED_IDX && wStrb_reg[0]) begin
                led_reg <= wData_reg[7:0];
            end
            // Override enables span two byte lanes
            if (wrIdx == OVR_CTRL_IDX) begin
                if (wStrb_reg[0]) begin
                    ovr_reg[7:0] <= wData_reg[7:0];
                end
                if (wStrb_reg[1]) begin
                    ovr_reg[9:8] <= wData_reg[9:8];
                end
            end
            // Analog channel select
            if (wrIdx == ANA_SEL_IDX && wStrb_reg[0]) begin
                anaSel_reg <= wData_reg[ANA_SEL_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // Handshakes come straight from the held flags
    assign awready = !awHave_reg;
    assign wready  = !wHave_reg;
    assign bvalid  = bValid_reg;
    assign bresp   = bResp_reg;

    // Address and data captured in either order; response follows both
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Idle: both channels ready, no response
            awHave_reg <= 1'b0;
            wHave_reg  <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg  <= RESP_OKAY;
            awAddr_reg <= 8'h00;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
        end else begin
            // Address channel taken
            if (awvalid && awready) begin
                awAddr_reg <= awaddr;
                awHave_reg <= 1'b1;
            end
            // Data channel taken
            if (wvalid && wready) begin
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
                wHave_reg <= 1'b1;
            end
            // Both halves held: write lands, response raised
            if (wrFire) begin
                awHave_reg <= 1'b0;
                wHave_reg  <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg  <= isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_reg && bready) begin
                // Response taken by the master
                bValid_reg <= 1'b0;
            end
        end
    end

    // Known register index check
    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == PORT_A_DATA_IDX) || (idx == PORT_B_DATA_IDX) ||
                   (idx == PORT_A_DIR_IDX)  || (idx == PORT_B_DIR_IDX)  ||
                   (idx == PORT_A_LED_IDX)  || (idx == OVR_CTRL_IDX)    ||
                   (idx == ANA_SEL_IDX)     || (idx == PIN_DRIVE_IDX);
    endfunction : isMapped

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    // A new address waits until the last data is taken
    assign arready = !rValid_reg;
    assign rvalid  = rValid_reg;
    assign rdata   = rData_reg;
    assign rresp   = rResp_reg;

    // Data view is sampled at the accept edge; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h0000_0000;
            rResp_reg  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            // Capture view and code at the accept edge
            rValid_reg <= 1'b1;
            rResp_reg  <= isMapped(addrToIdx(araddr)) ? RESP_OKAY : RESP_SLVERR;
            // Narrow registers read zero above their width
            unique case (addrToIdx(araddr))
                PORT_A_DATA_IDX: rData_reg <= {24'h0, aRead};
                PORT_B_DATA_IDX: rData_reg <= {24'h0, bRead};
                PORT_A_DIR_IDX:  rData_reg <= {24'h0, aDir};
                PORT_B_DIR_IDX:  rData_reg <= {24'h0, bDir};
                PORT_A_LED_IDX:  rData_reg <= {24'h0, led_reg};
                OVR_CTRL_IDX:    rData_reg <= {22'h0, ovr_reg};
                ANA_SEL_IDX:     rData_reg <= {27'h0, anaSel_reg};
                PIN_DRIVE_IDX:   rData_reg <= {16'h0, portBPad.outEnable,
                                               portAPad.outEnable};
                default:         rData_reg <= 32'h0000_0000;
            endcase
        end else if (rValid_reg && rready) begin
            // Data taken by the master
            rValid_reg <= 1'b0;
        end
    end

endmodule : gpab_top

//--- verif/gpab_top_asserts.sv
// Concurrent checks on the two-port GPIO top level
`timescale 1ns/1ps
module gpab_chk
    import gpab_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    // Pins
    input wire gpab_pad_t   portAPad,
    input wire logic [7:0]  portALedSink,
    input wire logic [7:0]  portAAnalogSel,
    input wire logic [7:0]  portBIn,
    input wire gpab_pad_t   portBPad,
    input wire logic [7:0]  portBPeriphIn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // --------------------------------
    // Write handshake steps
    // --------------------------------
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_wr_resp;
        ##[1:2] bvalid;
    endsequence

    a_led_needs_dir: assert property ((portALedSink & ~portAPad.outEnable) == 8'h00)
        else $error("LED sink on a pin not driven");
    a_od_no_high: assert property ((portBPad.outEnable[3:0] & portBPad.dataOut[3:0]) == 4'h0)
        else $error("open-drain pin driven high");
    a_ana_release: assert property ((portAAnalogSel & portAPad.outEnable) == 8'h00)
        else $error("analog pin still driven");
    a_ana_onehot: assert property ($onehot0(portAAnalogSel))
        else $error("more than one analog pin");
    a_periph_in: assert property (portBPeriphIn == portBIn)
        else $error("peripheral input differs from pin");
    a_rst_no_drive: assert property (disable iff (1'b0) $rose(rstn) |->
        (portAPad.outEnable == 8'h00) && (portBPad.outEnable == 8'h00))
        else $error("pin driven after reset");
    a_write_resp: assert property (s_wr_taken |-> s_wr_resp)
        else $error("write response late");
    a_resp_clear: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    a_read_lat: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_read_clear: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    a_ar_refuse: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
endmodule : gpab_chk

bind gpab_top gpab_chk u_chk (
    .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .portAPad(portAPad), .portALedSink(portALedSink), .portAAnalogSel(portAAnalogSel),
    .portBIn(portBIn), .portBPad(portBPad), .portBPeriphIn(portBPeriphIn)
);

//--- verif/gpab_board.sv
// Board model: resolves pad drive against external sources and pull-ups
`timescale 1ns/1ps
module gpab_board
    import gpab_pkg::*;
(
    // Pad drive from the block
    input wire gpab_pad_t   padA,
    input wire gpab_pad_t   padB,
    // External levels when a pin floats
    input wire logic [7:0]  extA,
    input wire logic [7:0]  extB,
    // Resolved pin levels
    output logic     [7:0]  pinA,
    output logic     [7:0]  pinB
);
    // A floating pin takes the outside level
    assign pinA = (padA.outEnable & padA.dataOut) | (~padA.outEnable & extA);
    // Low nibble of port B has pull-ups, so released lines read high
    assign pinB = (padB.outEnable & padB.dataOut) | (~padB.outEnable & (extB | 8'h0f));
endmodule : gpab_board

//--- verif/tb_gpab_top.sv
// Self-checking bench for the two-port GPIO block
`timescale 1ns/1ps
module tb_gpab_top
    import gpab_pkg::*;
;
    logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, pinA, pinB, ledSink, anaSel, pIn, extA, extB, pOut, pOe;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    gpab_pad_t   padA, padB;
    logic [7:0]  mLat [2], mDir [2], mLed, di;   // Reference model state
    logic [9:0]  mOvr, ovTab [6];
    logic [4:0]  mAna;
    int          bad_count, n_checks, cyc, seed;

    gpab_top dut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .portAIn(pinA), .portAPad(padA), .portALedSink(ledSink), .portAAnalogSel(anaSel),
        .portBIn(pinB), .portBPad(padB), .portBPeriph({pOut, pOe}), .portBPeriphIn(pIn));
    gpab_board board (.padA(padA), .padB(padB), .extA(extA), .extB(extB),
        .pinA(pinA), .pinB(pinB));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] anaMask(input logic [4:0] a);
        return (a < 5'h08) ? (8'h01 << a) : 8'h00;
    endfunction : anaMask

    // Expected {driven value, enable} of one port
    function automatic logic [15:0] padExp(input int p);
        logic [7:0] t, v, e;
        t = p ? {|mOvr[9:8], |mOvr[7:6], |mOvr[5:4], |mOvr[3:2], {2{mOvr[1]}}, {2{mOvr[0]}}}
              : 8'h00;
        v = (t & pOut) | (~t & mLat[p]);
        e = (t & pOe) | (~t & mDir[p]);
        e = p ? (e & ~(v & 8'h0f)) : (e & ~anaMask(mAna));
        return {v & e, e};
    endfunction : padExp

    function automatic logic [7:0] rdExp(input int p);
        logic [15:0] pe;
        pe = padExp(p);
        return (mDir[p] & mLat[p]) | (~mDir[p] & (pe[15:8] | (~pe[7:0] & (p ? extB | 8'h0f : extA))));
    endfunction : rdExp

    // Expected read-only pin drive view: {port B enables, port A enables}
    function automatic logic [31:0] drvExp();
        logic [15:0] pa, pb;
        pa = padExp(0);
        pb = padExp(1);
        return {16'h0, pb[7:0], pa[7:0]};
    endfunction : drvExp

    task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        chk(bresp, er);
    endtask : bw

    task automatic br(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : br

    // Register write that also updates the model
    task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
        bw({idx[5:0], 2'b00}, {22'h0, d[9:0]}, RESP_OKAY);
        case (idx)
            PORT_A_DATA_IDX: mLat[0] = d[7:0];
            PORT_B_DATA_IDX: mLat[1] = d[7:0];
            PORT_A_DIR_IDX:  mDir[0] = d[7:0];
            PORT_B_DIR_IDX:  mDir[1] = d[7:0];
            PORT_A_LED_IDX:  mLed = d[7:0];
            OVR_CTRL_IDX:    mOvr = d[9:0];
            default:         mAna = d[4:0];
        endcase
    endtask : wreg

    task automatic rreg(input logic [7:0] idx, input logic [31:0] exp);
        br({idx[5:0], 2'b00}, rd, rs);
        chk(rs, RESP_OKAY);
        chk(rd, exp);
    endtask : rreg

    task automatic chkPads;
        chk({padA.dataOut & padA.outEnable, padA.outEnable}, padExp(0));
        chk({padB.dataOut & padB.outEnable, padB.outEnable}, padExp(1));
        chk(ledSink, mLed & mDir[0] & ~anaMask(mAna));
        chk(anaSel, anaMask(mAna));
    endtask : chkPads

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    initial begin
        seed = 42; rstn = 1'b0; cyc = 0; bad_count = 0; n_checks = 0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
        awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
        extA = 8'h00; extB = 8'h00; pOut = 8'h00; pOe = 8'h00;
        mLat = '{8'hxx, 8'hxx}; mDir = '{8'h00, 8'h00}; mLed = 8'h00; mOvr = 10'h000;
        mAna = 5'h1f;
        ovTab = '{10'h001, 10'h002, 10'h00c, 10'h030, 10'h0c0, 10'h300};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rreg(PORT_A_DIR_IDX, 32'h0);
        rreg(PORT_B_DIR_IDX, 32'h0);
        rreg(ANA_SEL_IDX, 32'h1f);
        chkPads();
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            di = i[0] ? PORT_B_DATA_IDX : PORT_A_DATA_IDX;
            {extA, extB} <= 16'($random(seed));
            wreg(di, $random(seed));
            rreg(di, rdExp(i % 2));
            wreg(di + 8'h04, $random(seed));
            wreg(PORT_A_LED_IDX, $random(seed));
            rreg(PORT_A_LED_IDX, mLed);
            chkPads();
            rreg(di, rdExp(i % 2));
        end
        $display("data and direction done");
        wreg(PORT_A_DIR_IDX, 32'hff);
        for (int k = 0; k < 9; k++) begin
            wreg(ANA_SEL_IDX, k);
            chkPads();
        end
        wreg(ANA_SEL_IDX, 32'h1f);
        $display("analog select done");
        wreg(PORT_B_DIR_IDX, 32'hff);
        foreach (ovTab[j]) begin
            {pOut, pOe} <= 16'($random(seed));
            wreg(OVR_CTRL_IDX, {22'h0, ovTab[j]});
            chkPads();
            rreg(PORT_B_DIR_IDX, mDir[1]);
            rreg(OVR_CTRL_IDX, {22'h0, mOvr});
            rreg(PIN_DRIVE_IDX, drvExp());
        end
        wreg(OVR_CTRL_IDX, 32'h0);
        $display("overrides done");
        bw(8'h44, 32'h5a, RESP_SLVERR);
        br(8'h44, rd, rs);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0);
        $display("unmapped access done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        mDir = '{8'h00, 8'h00}; mLed = 8'h00; mAna = 5'h1f;
        rreg(PORT_B_DIR_IDX, 32'h0);
        wreg(PORT_A_DIR_IDX, 32'hff);
        rreg(PORT_A_DATA_IDX, mLat[0]);
        $display("second reset done");
        test_done();
    end
endmodule : tb_gpab_top
